// File: design/sfa_acq.sv
`timescale 1ns/10ps
// Summary of operation
// - Frames out on stream, configuration via slave.
// - Four read/write 32-bit configuration registers.
// - Register 0 bits 15-8 read live status.
// - Byte lanes select affected register bytes.
// - Command bits: enable, gain, ADC clock halving.
// - Soft reset clears logic, keeps registers.
// - Status: sending, trigger delaying, integration active.
// - Status: ADC active, finished, sync tx, rx.
// - Trigger delayed by 12-bit programmed count.
// - Sensor clock is master over 2(div+1).
// - Clock rises one period after delayed trigger.
// - Realignment only lengthens clock phases.
// - Integration pulse rises on first clock rise.
// - Integration timed by 12-bit sensor-clock counter.
// - Triggers during integration are ignored.
// - Samples double-buffered, copied at merge start.
// - No new low phase before readout completes.
// - Sample triggers generated by counting sensor clocks.
// - Each trigger converts, then serial readout.
// - ADC machine runs full or half rate.
module sfa_acq import sfa_pkg::*; #(
  parameter int NUM_CH = 64,
  parameter int SMP_W = 16,
  parameter int DIV_W = 5,
  parameter int DLY_W = 12,
  parameter int INT_W = 12,
  parameter int CNV_W = 8
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire sfa_mm_req_s mm_req_in,
  output logic [31:0] readdata_out,
  output sfa_st_s st_out,
  input wire logic st_ready_in,
  input wire logic frame_trig_in,
  input wire logic adc_sdo_in,
  input wire logic sync_tx_busy_in,
  input wire logic sync_rx_busy_in,
  output logic sensor_clk_out,
  output logic sensor_reset_out,
  output logic gain_out,
  output logic conversion_strobe_out,
  output logic adc_sck_out,
  output logic [7:0] sync_link_divider_out
);
  // ==========================================================
  // Parameter checks.
  localparam int CH_W = $clog2(NUM_CH) + 1;
  localparam int BIT_W = $clog2(SMP_W + 2);
  localparam logic [CH_W-1:0] LAST_CH = CH_W'(NUM_CH - 1);
  localparam logic [CH_W-1:0] ALL_CH = CH_W'(NUM_CH);
  if (NUM_CH < 1 || SMP_W < 2 || SMP_W > 32) begin : g_bad_size
    $error("sfa_acq: unsupported channel count or sample width");
  end
  if (DIV_W > 8 || DLY_W > 16 || INT_W > 16 || CNV_W > 8) begin : g_bad_field
    $error("sfa_acq: counter wider than its register field");
  end
  // ==========================================================
  // State.
  typedef struct packed {
    logic [31:0] reg0;
    logic [31:0] reg1;
    logic [31:0] reg2;
    logic [31:0] reg4;
    logic [31:0] rdata;
    logic [2:0] trg_sy;
    logic [1:0] sdo_sy;
    logic dly_on;
    logic [DLY_W-1:0] dly_cnt;
    logic sclk;
    logic [DIV_W:0] sck_cnt;
    logic align;
    logic shut;
    logic [INT_W-1:0] int_cnt;
    logic acq_run;
    logic acq_done;
    logic [4:0] vclk;
    logic [CH_W-1:0] ch_cnt;
    logic adc_go;
    logic adc_ph;
    sfa_adc_e adc_st;
    logic [CNV_W-1:0] cnv_cnt;
    logic conversion_strobe;
    logic sck;
    logic [BIT_W-1:0] bit_cnt;
    logic [SMP_W-1:0] shreg;
    logic [CH_W-1:0] adc_ch;
    logic [NUM_CH-1:0][SMP_W-1:0] abuf;
    logic [NUM_CH-1:0][SMP_W-1:0] tbuf;
    logic mrg_pend;
    logic tx_on;
    logic [CH_W-1:0] tx_idx;
    sfa_st_s st;
  } sfa_state_s;
  sfa_state_s s_r;
  sfa_state_s s_nxt;
  sfa_state_s keep;
  logic [7:0] stat_w;
  logic trg_edge;
  logic fire;
  logic rise;
  logic fin;
  logic [DIV_W-1:0] div;
  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] d,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[LANE_W*i +: LANE_W] = d[LANE_W*i +: LANE_W];
      end
    end
    return r;
  endfunction
  // ==========================================================
  // Live status byte.
  assign stat_w[ST_SEND] = s_r.tx_on;
  assign stat_w[ST_TRGD] = s_r.dly_on;
  assign stat_w[ST_INTG] = s_r.shut;
  assign stat_w[ST_ADCA] = s_r.acq_run | s_r.acq_done;
  assign stat_w[ST_ADCF] = s_r.acq_done;
  assign stat_w[ST_TX] = sync_tx_busy_in;
  assign stat_w[ST_RX] = sync_rx_busy_in;
  assign stat_w[ST_SPARE] = 1'b0;
  // Only the second and third flops are compared, never the first.
  assign trg_edge = s_r.trg_sy[1] & ~s_r.trg_sy[2];
  assign div = s_r.reg0[DIV_LSB +: DIV_W];
  // ==========================================================
  // Next-state logic.
  always_comb begin
    keep = '0;
    s_nxt = s_r;
    fire = 1'b0;
    rise = 1'b0;
    fin = 1'b0;
    s_nxt.trg_sy = {s_r.trg_sy[1:0], frame_trig_in};
    s_nxt.sdo_sy = {s_r.sdo_sy[0], adc_sdo_in};
    if (mm_req_in.wr) begin
      if (mm_req_in.addr == IDX_CTRL) begin
        s_nxt.reg0 = be_merge(s_r.reg0, mm_req_in.wdata, mm_req_in.be & CTRL_BE_MASK);
      end else if (mm_req_in.addr == IDX_TIME) begin
        s_nxt.reg1 = be_merge(s_r.reg1, mm_req_in.wdata, mm_req_in.be);
      end else if (mm_req_in.addr == IDX_LINK) begin
        s_nxt.reg2 = be_merge(s_r.reg2, mm_req_in.wdata, mm_req_in.be);
      end else if (mm_req_in.addr == IDX_SPARE) begin
        s_nxt.reg4 = be_merge(s_r.reg4, mm_req_in.wdata, mm_req_in.be);
      end
    end
    if (mm_req_in.rd) begin
      if (mm_req_in.addr == IDX_CTRL) begin
        s_nxt.rdata = s_r.reg0 | (32'(stat_w) << STAT_LSB);
      end else if (mm_req_in.addr == IDX_TIME) begin
        s_nxt.rdata = s_r.reg1;
      end else if (mm_req_in.addr == IDX_LINK) begin
        s_nxt.rdata = s_r.reg2;
      end else if (mm_req_in.addr == IDX_SPARE) begin
        s_nxt.rdata = s_r.reg4;
      end else begin
        s_nxt.rdata = '0;
      end
    end
    // Trigger delay; a busy shutter or pending alignment drops the edge.
    if (trg_edge && s_r.reg0[CMD_EN] && !s_r.dly_on && !s_r.align && !s_r.shut) begin
      s_nxt.dly_on = 1'b1;
      s_nxt.dly_cnt = s_r.reg1[DELAY_LSB +: DLY_W];
    end else if (s_r.dly_on) begin
      if (s_r.dly_cnt == '0) begin
        s_nxt.dly_on = 1'b0;
        fire = 1'b1;
      end else begin
        s_nxt.dly_cnt = s_r.dly_cnt - 1'b1;
      end
    end
    // Sensor clock; realignment reloads a running high phase in full and stretches a running low phase to one period.
    if (fire) begin
      s_nxt.align = 1'b1;
      s_nxt.sck_cnt = s_r.sclk ? {1'b0, div} : {div, 1'b1};
    end else if (s_r.sck_cnt == '0) begin
      s_nxt.sclk = ~s_r.sclk;
      s_nxt.sck_cnt = {1'b0, div};
      rise = ~s_r.sclk;
    end else begin
      s_nxt.sck_cnt = s_r.sck_cnt - 1'b1;
    end
    // ADC machine; placed before the sampler so a new request wins.
    s_nxt.adc_ph = ~s_r.adc_ph;
    if (!s_r.reg0[CMD_HALVE] || s_r.adc_ph) begin
      case (s_r.adc_st)
        ADC_IDLE: begin
          if (s_r.adc_go) begin
            s_nxt.adc_go = 1'b0;
            s_nxt.conversion_strobe = 1'b1;
            s_nxt.cnv_cnt = s_r.reg0[CNV_LSB +: CNV_W];
            s_nxt.adc_ch = s_r.ch_cnt - 1'b1;
            s_nxt.adc_st = ADC_CONV;
          end
        end
        ADC_CONV: begin
          if (s_r.cnv_cnt == '0) begin
            s_nxt.conversion_strobe = 1'b0;
            s_nxt.bit_cnt = '0;
            s_nxt.adc_st = ADC_READ;
          end else begin
            s_nxt.cnv_cnt = s_r.cnv_cnt - 1'b1;
          end
        end
        ADC_READ: begin
          if (!s_r.sck) begin
            s_nxt.sck = 1'b1;
          end else begin
            // One extra bit is clocked to absorb the input synchroniser latency.
            s_nxt.sck = 1'b0;
            s_nxt.shreg = {s_r.shreg[SMP_W-2:0], s_r.sdo_sy[1]};
            s_nxt.bit_cnt = s_r.bit_cnt + 1'b1;
            if (s_r.bit_cnt == BIT_W'(SMP_W)) begin
              fin = 1'b1;
              s_nxt.adc_st = ADC_IDLE;
            end
          end
        end
        default: s_nxt.adc_st = ADC_IDLE;
      endcase
    end
    // Shutter and sample triggers, both stepped on sensor clock rises.
    if (rise) begin
      if (s_r.align) begin
        s_nxt.align = 1'b0;
        s_nxt.shut = 1'b1;
        s_nxt.int_cnt = s_r.reg1[INTEG_LSB +: INT_W];
        s_nxt.acq_done = 1'b0;
      end else if (s_r.shut) begin
        if (s_r.int_cnt != '0) begin
          s_nxt.int_cnt = s_r.int_cnt - 1'b1;
        end else if (!s_r.acq_run) begin
          s_nxt.shut = 1'b0;
          s_nxt.acq_run = 1'b1;
          s_nxt.acq_done = 1'b0;
          s_nxt.vclk = VID_FIRST_LD;
          s_nxt.ch_cnt = '0;
        end
      end
      if (s_r.acq_run && s_r.ch_cnt != ALL_CH) begin
        if (s_r.vclk == '0) begin
          s_nxt.vclk = VID_PITCH_LD;
          s_nxt.adc_go = 1'b1;
          s_nxt.ch_cnt = s_r.ch_cnt + 1'b1;
        end else begin
          s_nxt.vclk = s_r.vclk - 1'b1;
        end
      end
    end
    // Stream output; the buffer copy happens as the frame starts.
    if (s_r.st.valid && st_ready_in) begin
      if (s_r.st.eop) begin
        s_nxt.st.valid = 1'b0;
        s_nxt.st.eop = 1'b0;
        s_nxt.tx_on = 1'b0;
      end else begin
        s_nxt.st.data = 32'(s_r.tbuf[s_r.tx_idx]);
        s_nxt.st.sop = 1'b0;
        s_nxt.st.eop = (s_r.tx_idx == LAST_CH);
        s_nxt.tx_idx = s_r.tx_idx + 1'b1;
      end
    end else if (!s_r.tx_on && s_r.mrg_pend) begin
      s_nxt.mrg_pend = 1'b0;
      s_nxt.tx_on = 1'b1;
      s_nxt.tbuf = s_r.abuf;
      s_nxt.tx_idx = '0;
      s_nxt.st.valid = 1'b1;
      s_nxt.st.sop = 1'b1;
      s_nxt.st.eop = 1'b0;
      s_nxt.st.data = {s_r.reg2[HDR_LSB +: 16], s_r.reg2[ANY_LSB +: 8], stat_w};
    end
    if (fin) begin
      s_nxt.abuf[s_r.adc_ch] = s_nxt.shreg;
      if (s_r.adc_ch == LAST_CH) begin
        s_nxt.acq_run = 1'b0;
        s_nxt.acq_done = 1'b1;
        s_nxt.mrg_pend = 1'b1;
      end
    end
    // Software reset holds all logic but the register bank and read data cleared.
    if (s_r.reg0[CMD_SRST]) begin
      keep = s_nxt;
      s_nxt = '0;
      s_nxt.adc_st = ADC_IDLE;
      s_nxt.reg0 = keep.reg0;
      s_nxt.reg1 = keep.reg1;
      s_nxt.reg2 = keep.reg2;
      s_nxt.reg4 = keep.reg4;
      s_nxt.rdata = keep.rdata;
    end
  end
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_r <= '0;
      s_r.adc_st <= ADC_IDLE;
      s_r.reg0 <= REG0_RST;
      s_r.reg1 <= REGX_RST;
      s_r.reg2 <= REGX_RST;
      s_r.reg4 <= REGX_RST;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign readdata_out = s_r.rdata;
  assign st_out = s_r.st;
  assign sensor_clk_out = s_r.sclk;
  assign sensor_reset_out = s_r.shut;
  assign gain_out = s_r.reg0[CMD_GAIN];
  assign conversion_strobe_out = s_r.conversion_strobe;
  assign adc_sck_out = s_r.sck;
  assign sync_link_divider_out = s_r.reg2[SYNC_LSB +: 8];
  // ==========================================================
  // Checks. A phase is judged against the divider loaded with it; reset voids it.
  logic [7:0] a_cnt;
  logic [7:0] ph_cnt, ph_div;
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      a_cnt <= 8'h00;
      ph_cnt <= 8'h00;
      ph_div <= 8'h00;
    end else begin
      a_cnt <= fire ? 8'h01 : (s_r.align ? a_cnt + 8'h01 : 8'h00);
      ph_cnt <= (s_nxt.sclk != s_r.sclk) ? 8'h00 : ph_cnt + 8'h01;
      ph_div <= s_r.reg0[CMD_SRST] ? 8'h00 : ((fire || s_nxt.sclk != s_r.sclk) ? 8'(div) : ph_div);
    end
  end
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!nrst_in || s_r.reg0[CMD_SRST]);
  sequence seq_rd_ctrl;
    mm_req_in.rd && mm_req_in.addr == IDX_CTRL;
  endsequence
  sequence seq_last_beat;
    st_out.valid && st_out.eop && st_ready_in;
  endsequence
  chk_status_read: assert property (seq_rd_ctrl |=> readdata_out[15:8] == $past(stat_w))
    else $error("status byte not live on read");
  chk_gain_write: assert property ((mm_req_in.wr && mm_req_in.addr == IDX_CTRL &&
      mm_req_in.be[0]) |=> gain_out == $past(mm_req_in.wdata[CMD_GAIN]))
    else $error("gain bit did not follow write");
  chk_status_unwritten: assert property (mm_req_in.wr |=> s_r.reg0[15:8] == 8'h00)
    else $error("status lane was written");
  chk_trig_ignored: assert property ((trg_edge && s_r.shut && !s_r.dly_on) |=> !s_r.dly_on)
    else $error("trigger taken during integration");
  chk_delay_count: assert property ((s_r.dly_on && s_r.dly_cnt != '0) |=>
      s_r.dly_on && s_r.dly_cnt == $past(s_r.dly_cnt) - 1'b1)
    else $error("trigger delay counter misbehaved");
  chk_align_period: assert property ($rose(s_r.shut) |-> $past(a_cnt) == 8'(2 * div + 2))
    else $error("shutter not one sensor period after trigger");
  chk_phase_length: assert property ($changed(s_r.sclk) |-> $past(ph_cnt) >= $past(ph_div))
    else $error("sensor clock phase shortened");
  chk_shut_edge: assert property ($rose(s_r.shut) |-> $rose(s_r.sclk))
    else $error("shutter rise off clock edge");
  chk_readout_first: assert property ($fell(s_r.shut) |-> !$past(s_r.acq_run))
    else $error("shutter fell during readout");
  chk_half_rate: assert property (($changed(s_r.sck) && s_r.reg0[CMD_HALVE]) |=>
      $stable(s_r.sck))
    else $error("serial clock too fast in half rate");
  chk_frame_end: assert property (seq_last_beat |=> !st_out.valid ##1 !st_out.sop || st_out.valid)
    else $error("stream did not end after last beat");
  chk_buffer_copy: assert property ($rose(s_r.tx_on) |-> s_r.tbuf == $past(s_r.abuf))
    else $error("transmit buffer not copied at frame start");
endmodule

// File: design/sfa_pkg.sv
package sfa_pkg;
  // ==========================================================
  // Register indices; the byte address is four times the index.
  localparam logic [2:0] IDX_CTRL = 3'h0;
  localparam logic [2:0] IDX_TIME = 3'h1;
  localparam logic [2:0] IDX_LINK = 3'h2;
  localparam logic [2:0] IDX_SPARE = 3'h4;
  localparam int LANE_W = 8;
  localparam logic [3:0] CTRL_BE_MASK = 4'hd;
  localparam logic [31:0] REG0_RST = 32'h1006_0000;
  localparam logic [31:0] REGX_RST = 32'h0000_0000;
  // ==========================================================
  // Command bits, field positions and status bits.
  localparam int CMD_EN = 0;
  localparam int CMD_GAIN = 1;
  localparam int CMD_HALVE = 2;
  localparam int CMD_SRST = 3;
  localparam int STAT_LSB = 8;
  localparam int DIV_LSB = 16;
  localparam int CNV_LSB = 24;
  localparam int DELAY_LSB = 0;
  localparam int INTEG_LSB = 16;
  localparam int SYNC_LSB = 0;
  localparam int ANY_LSB = 8;
  localparam int HDR_LSB = 16;
  localparam int ST_SEND = 0;
  localparam int ST_TRGD = 1;
  localparam int ST_INTG = 2;
  localparam int ST_ADCA = 3;
  localparam int ST_ADCF = 4;
  localparam int ST_TX = 5;
  localparam int ST_RX = 6;
  localparam int ST_SPARE = 7;
  // ==========================================================
  // Readout timing in sensor clocks, stored as reload values.
  localparam logic [4:0] VID_FIRST_LD = 5'h11;
  localparam logic [4:0] VID_PITCH_LD = 5'h03;
  typedef enum logic [2:0] {
    ADC_IDLE = 3'h1,
    ADC_CONV = 3'h2,
    ADC_READ = 3'h4
  } sfa_adc_e;
  typedef struct packed {
    logic [2:0] addr;
    logic [3:0] be;
    logic rd;
    logic wr;
    logic [31:0] wdata;
  } sfa_mm_req_s;
  typedef struct packed {
    logic [31:0] data;
    logic valid;
    logic sop;
    logic eop;
  } sfa_st_s;
endpackage

// File: sim/sfa_st_sink.sv
`timescale 1ns/10ps
// ==========================================================
// Stream sink model
module sfa_st_sink import sfa_pkg::*; (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire sfa_st_s st_in,
  input wire logic stall_in,
  output logic ready_out
);
  logic [33:0] beats[$];
  logic tog_r;
  // Stalling on alternate cycles proves that the source holds each beat until taken.
  assign ready_out = !stall_in || tog_r;
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tog_r <= 1'b0;
    end else begin
      tog_r <= ~tog_r;
      if (st_in.valid && ready_out) begin
        beats.push_back({st_in.sop, st_in.eop, st_in.data});
      end
    end
  end
endmodule

// File: sim/sensor_frame_acquisition_tb.sv
`timescale 1ns/10ps
module sensor_frame_acquisition_tb import sfa_pkg::*; ;
  localparam int NCH = 2;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  sfa_mm_req_s req = '0;
  logic [31:0] rdata;
  logic [31:0] v;
  sfa_st_s st;
  logic ready, sclk, shut, gain, conversion_strobe, sck;
  logic trig = 1'b0;
  logic sdo = 1'b1;
  logic txb = 1'b0;
  logic rxb = 1'b0;
  logic stall = 1'b0;
  logic sclk_d, shut_d, cnv_d, sck_d, shut_sync;
  logic [7:0] sdiv;
  int miscompares = 0;
  int check_count = 0;
  int cyc, rise_prev, rise_last, shut_rises, hi_rises, cnv_rises, cnv_run, cnv_last, sck_rises;
  always #4 clk = ~clk;
  sfa_acq #(.NUM_CH(NCH)) i_sfa_acq (.ref_clk_in(clk), .nrst_in(nrst), .mm_req_in(req),
    .readdata_out(rdata), .st_out(st), .st_ready_in(ready), .frame_trig_in(trig),
    .adc_sdo_in(sdo), .sync_tx_busy_in(txb), .sync_rx_busy_in(rxb),
    .sensor_clk_out(sclk), .sensor_reset_out(shut), .gain_out(gain),
    .conversion_strobe_out(conversion_strobe), .adc_sck_out(sck), .sync_link_divider_out(sdiv));
  sfa_st_sink i_sfa_st_sink (.clk_in(clk), .nrst_in(nrst), .st_in(st), .stall_in(stall),
    .ready_out(ready));
  // ==========================================================
  // Output monitor, sampled at the falling edge where outputs are settled
  always @(negedge clk) begin
    cyc++;
    if (sclk && !sclk_d) begin
      rise_prev = rise_last;
      rise_last = cyc;
      if (shut && shut_d) hi_rises++;
    end
    if (shut && !shut_d) begin
      shut_rises++;
      shut_sync = sclk && !sclk_d;
    end
    if (conversion_strobe && !cnv_d) cnv_rises++;
    if (sck && !sck_d) sck_rises++;
    if (conversion_strobe) cnv_run++;
    else if (cnv_d) begin
      cnv_last = cnv_run;
      cnv_run = 0;
    end
    sclk_d = sclk;
    shut_d = shut;
    cnv_d = conversion_strobe;
    sck_d = sck;
  end
  // ==========================================================
  // Bus tasks and comparisons
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic expired();
    miscompares++;
    $display("wait expired at %0t", $time);
    give_verdict();
  endtask
  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge clk);
    req = '{addr: a, be: b, rd: 1'b0, wr: 1'b1, wdata: d};
    @(negedge clk);
    req.wr = 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [31:0] d);
    @(negedge clk);
    req = '{addr: a, be: 4'hf, rd: 1'b1, wr: 1'b0, wdata: 32'h0};
    @(negedge clk);
    req.rd = 1'b0;
    d = rdata;
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a, v);
    check(v & m, e);
  endtask
  task automatic poll_bit(input int b, input int lim);
    for (int i = 0; i <= lim; i++) begin
      if (i == lim) expired();
      rd(IDX_CTRL, v);
      if (v[STAT_LSB + b] === 1'b1) break;
    end
  endtask
  task automatic wait_lvl(ref logic s, input logic lvl, input int lim);
    for (int i = 0; i <= lim; i++) begin
      if (i == lim) expired();
      @(negedge clk);
      #1;
      if (s === lvl) break;
    end
  endtask
  task automatic pulse_trig();
    @(negedge clk);
    trig = 1'b1;
    repeat (4) @(negedge clk);
    trig = 1'b0;
  endtask
  task automatic frame_chk(input logic [31:0] cnv_exp, input logic [15:0] smp);
    for (int i = 0; i <= 4000; i++) begin
      if (i == 4000) expired();
      @(negedge clk);
      if (i_sfa_st_sink.beats.size() == NCH + 1) break;
    end
    check(i_sfa_st_sink.beats[0][33:8], 26'h280_005a);
    for (int k = 1; k <= NCH; k++) begin
      check(i_sfa_st_sink.beats[k], {1'b0, k == NCH, 16'h0000, smp});
    end
    check(cnv_rises, NCH);
    check(cnv_last, cnv_exp);
    check(sck_rises, NCH * 17);
    i_sfa_st_sink.beats.delete();
    cnv_rises = 0;
    sck_rises = 0;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    rdchk(IDX_CTRL, 32'hffff_ffff, REG0_RST);
    rdchk(IDX_TIME, 32'hffff_ffff, REGX_RST);
    rdchk(IDX_LINK, 32'hffff_ffff, REGX_RST);
    rdchk(IDX_SPARE, 32'hffff_ffff, REGX_RST);
    $display("test reset values done");
    wr(IDX_TIME, 4'hf, 32'h1122_3344);
    wr(IDX_TIME, 4'h6, 32'haabb_ccdd);
    wr(IDX_TIME, 4'h1, 32'h0);
    rdchk(IDX_TIME, 32'hffff_ffff, 32'h11bb_cc00);
    wr(IDX_CTRL, 4'h2, 32'h0000_ff00);
    rdchk(IDX_CTRL, 32'hffff_ffff, REG0_RST);
    wr(3'h3, 4'hf, 32'hffff_ffff);
    rdchk(3'h3, 32'hffff_ffff, 32'h0);
    $display("test lanes done");
    wr(IDX_CTRL, 4'h1, 32'h2);
    check(gain, 1'b1);
    wr(IDX_CTRL, 4'h1, 32'h0);
    check(gain, 1'b0);
    txb = 1'b1;
    rxb = 1'b1;
    rdchk(IDX_CTRL, 32'h0000_ff00, 32'h0000_6000);
    txb = 1'b0;
    rxb = 1'b0;
    wr(IDX_LINK, 4'hf, 32'h8000_5a32);
    check(sdiv, 32'h32);
    $display("test command and status done");
    // Conversion length 0x40 keeps the pulse above 500 ns at the full tick rate.
    wr(IDX_CTRL, 4'hf, 32'h400f_0001);
    wr(IDX_TIME, 4'hf, 32'h0003_0010);
    repeat (100) @(negedge clk);
    check(rise_last - rise_prev, 32);
    shut_rises = 0;
    hi_rises = 0;
    stall = 1'b1;
    pulse_trig();
    poll_bit(ST_TRGD, 30);
    check(shut, 1'b0);
    wait_lvl(shut, 1'b1, 300);
    check(shut_sync, 1'b1);
    pulse_trig();
    rdchk(IDX_CTRL, 32'h0000_0400, 32'h0000_0400);
    wait_lvl(shut, 1'b0, 300);
    check(hi_rises, 3);
    poll_bit(ST_SEND, 1500);
    frame_chk(32'd65, 16'hffff);
    check(shut_rises, 1);
    $display("test full rate frame done");
    wr(IDX_CTRL, 4'hf, 32'h200f_0005);
    stall = 1'b0;
    sdo = 1'b0;
    pulse_trig();
    wait_lvl(shut, 1'b1, 300);
    frame_chk(32'd66, 16'h0000);
    $display("test halved rate frame done");
    pulse_trig();
    wait_lvl(shut, 1'b1, 300);
    wr(IDX_CTRL, 4'h1, 32'h9);
    @(negedge clk);
    check({shut, conversion_strobe, sclk}, 32'h0);
    rdchk(IDX_TIME, 32'hffff_ffff, 32'h0003_0010);
    rdchk(IDX_CTRL, 32'hffff_00ff, 32'h200f_0009);
    wr(IDX_CTRL, 4'h1, 32'h0);
    $display("test soft reset done");
    give_verdict();
  end
endmodule
